/* pfpc_regs.vh */
// register map, field positions and reset values of the port filter and pull-up control
`ifndef PFPC_REGS_VH
`define PFPC_REGS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PFPC_FILTER_OFS 12'h000
`define PFPC_PULLUP_OFS 12'h004
// ------------------------------------------------------------
// input_filter_select fields (lsb positions)
// ------------------------------------------------------------
`define PFPC_PORTA_LSB 0
`define PFPC_PORTB_LSB 2
`define PFPC_PORTC_LSB 4
`define PFPC_TWO_WIRE_LSB 10
`define PFPC_TIMER_LSB 12
`define PFPC_SET_ONE_LSB 24
`define PFPC_SET_TWO_LSB 26
`define PFPC_SET_THREE_LSB 29
// bits that hold state; all others read as zero
`define PFPC_FILTER_MASK 32'hff00_3c3f
`define PFPC_FILTER_RESET 32'h0000_0000
// ------------------------------------------------------------
// pin_pullup_enable_low fields
// ------------------------------------------------------------
`define PFPC_PULLUP_LSB 18
`define PFPC_PULLUP_MASK 32'h003c_0000
`define PFPC_PULLUP_RESET 32'h0000_0000
// ------------------------------------------------------------
// filter clock divider
// ------------------------------------------------------------
`define PFPC_DIV_WIDTH 12
`define PFPC_SET_ONE_BASE 1
`define PFPC_SET_TWO_BASE 5
`endif

/* pfpc_filter.v */
// glitch filter for a group of synchronised inputs
`timescale 1ns/10ps
`default_nettype none
module pfpc_filter #(
   parameter WIDTH = 8
) (
   input wire pclk,
   input wire presetn,
   input wire bypass,
   input wire tick,
   input wire [WIDTH-1:0] sync_in,
   output reg [WIDTH-1:0] filt_out
);
   reg [WIDTH-1:0] last_sample; // sample taken at the previous filter edge
   wire [WIDTH-1:0] moved; // bits that changed between filter edges

   assign moved = sync_in ^ last_sample;

   // ------------------------------------------------------------
   // sampling
   // ------------------------------------------------------------
   // a level passes only when two consecutive filter edges agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_sample <= {WIDTH{1'b0}};
         filt_out <= {WIDTH{1'b0}};
      end else if (bypass) begin
         // unfiltered path follows the pin every cycle
         last_sample <= sync_in;
         filt_out <= sync_in;
      end else if (tick) begin
         last_sample <= sync_in;
         filt_out <= (sync_in & ~moved) | (filt_out & moved); // R10
      end
   end
endmodule // pfpc_filter
`default_nettype wire

/* pfpc_top.v */
// port input filter clock selection and port c pull-up control with apb registers
//
// How it works
// R1: timer filter: off, set one, two, three
// R2: two-wire filter: off, one, two, bus clock
// R3: port c filter: bus, one, two, three
// R4: port b filter: bus, one, two, three
// R5: port a filter: bus, one, two, three
// R6: reserved bits ignore writes, read zero
// R7: bits 21..18 enable port c 5..2 pull-ups
// R8: pull-up acts only on input pins
// R9: set one divides by 2,4,8,16
// R10: level passes after consecutive equal samples
`timescale 1ns/10ps
`default_nettype none
`include "pfpc_regs.vh"
module pfpc_top #(
   parameter DIV_WIDTH = `PFPC_DIV_WIDTH
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] timer_channel_in,
   input wire two_wire_scl_in,
   input wire two_wire_sda_in,
   input wire [7:0] porta_in,
   input wire [7:0] portb_in,
   input wire [7:0] portc_in,
   input wire [3:0] portc_hi_output_en,
   input wire [3:0] portc_hi_input_en,
   output wire [1:0] timer_channel_filt,
   output wire [1:0] two_wire_filt,
   output wire [7:0] porta_filt,
   output wire [7:0] portb_filt,
   output wire [7:0] portc_filt,
   output reg [3:0] portc_pullup_on
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg [31:0] input_filter_select; // filter selection register
   reg [31:0] pin_pullup_enable_low; // pull-up enable register
   reg [DIV_WIDTH-1:0] div_count; // free-running prescaler
   reg [27:0] pin_meta; // first synchroniser stage
   reg [27:0] pin_sync; // second synchroniser stage
   wire [27:0] pin_raw; // all filtered pins
   wire access; // apb access phase
   wire hit_filter; // address decodes filter register
   wire hit_pullup; // address decodes pull-up register
   wire [1:0] set_one_code;
   wire [2:0] set_two_code;
   wire [2:0] set_three_code;
   wire tick_one; // filter clock set one enable
   wire tick_two; // filter clock set two enable
   wire tick_three; // filter clock set three enable
   wire [1:0] timer_sel;
   wire [1:0] two_wire_sel;
   wire [1:0] porta_sel;
   wire [1:0] portb_sel;
   wire [1:0] portc_sel;
   wire [3:0] pullup_en; // port c bits 5..2

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // one-cycle pulse each time the low n bits of the prescaler wrap
   function wrap_tick;
      input [DIV_WIDTH-1:0] count;
      input [3:0] nbits;
      integer i;
      begin
         wrap_tick = 1'b1;
         for (i = 0; i < DIV_WIDTH; i = i + 1) begin
            if (i < nbits && !count[i]) begin
               wrap_tick = 1'b0;
            end
         end
      end
   endfunction

   // map a two-bit select to the enable of its filter clock
   function pick_tick;
      input [1:0] code;
      input code0_tick;
      input code3_tick;
      input t1;
      input t2;
      begin
         case (code)
            2'h0: pick_tick = code0_tick;
            2'h1: pick_tick = t1;
            2'h2: pick_tick = t2;
            default: pick_tick = code3_tick;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // register fields
   // ------------------------------------------------------------
   assign timer_sel = input_filter_select[`PFPC_TIMER_LSB +: 2];
   assign two_wire_sel = input_filter_select[`PFPC_TWO_WIRE_LSB +: 2];
   assign porta_sel = input_filter_select[`PFPC_PORTA_LSB +: 2];
   assign portb_sel = input_filter_select[`PFPC_PORTB_LSB +: 2];
   assign portc_sel = input_filter_select[`PFPC_PORTC_LSB +: 2];
   assign set_one_code = input_filter_select[`PFPC_SET_ONE_LSB +: 2];
   assign set_two_code = input_filter_select[`PFPC_SET_TWO_LSB +: 3];
   assign set_three_code = input_filter_select[`PFPC_SET_THREE_LSB +: 3];
   assign pullup_en = pin_pullup_enable_low[`PFPC_PULLUP_LSB +: 4];

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign access = psel & penable;
   assign hit_filter = (paddr == `PFPC_FILTER_OFS);
   assign hit_pullup = (paddr == `PFPC_PULLUP_OFS);

   // one wait state: pready is high in the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (access && !pready) begin
         pready <= 1'b1;
         pslverr <= ~(hit_filter | hit_pullup); // unmapped address
         if (hit_filter) begin
            prdata <= input_filter_select;
         end else if (hit_pullup) begin
            prdata <= pin_pullup_enable_low;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // writes land at the edge where pready is sampled high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_filter_select <= `PFPC_FILTER_RESET;
         pin_pullup_enable_low <= `PFPC_PULLUP_RESET;
      end else if (access && pready && pwrite) begin
         if (hit_filter) begin
            input_filter_select <= pwdata & `PFPC_FILTER_MASK; // R6
         end
         if (hit_pullup) begin
            pin_pullup_enable_low <= pwdata & `PFPC_PULLUP_MASK; // R6 R7
         end
      end
   end

   // ------------------------------------------------------------
   // filter clock divider
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= {DIV_WIDTH{1'b0}};
      end else begin
         div_count <= div_count + 1'b1;
      end
   end

   // set one: 2,4,8,16; sets two and three: 32 up to 4096
   assign tick_one = wrap_tick(div_count, 4'd`PFPC_SET_ONE_BASE + {2'h0, set_one_code}); // R9
   assign tick_two = wrap_tick(div_count, 4'd`PFPC_SET_TWO_BASE + {1'h0, set_two_code});
   assign tick_three = wrap_tick(div_count, 4'd`PFPC_SET_TWO_BASE + {1'h0, set_three_code});

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   assign pin_raw = {timer_channel_in, two_wire_scl_in, two_wire_sda_in,
                     porta_in, portb_in, portc_in};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 28'h000_0000;
         pin_sync <= 28'h000_0000;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // filters
   // ------------------------------------------------------------
   pfpc_filter #(.WIDTH(2)) u_timer (
      .pclk(pclk), .presetn(presetn),
      .bypass(timer_sel == 2'h0), // R1
      .tick(pick_tick(timer_sel, 1'b1, tick_three, tick_one, tick_two)), // R1
      .sync_in(pin_sync[27:26]), .filt_out(timer_channel_filt)
   );

   pfpc_filter #(.WIDTH(2)) u_two_wire (
      .pclk(pclk), .presetn(presetn),
      .bypass(two_wire_sel == 2'h0), // R2
      .tick(pick_tick(two_wire_sel, 1'b1, 1'b1, tick_one, tick_two)), // R2
      .sync_in(pin_sync[25:24]), .filt_out(two_wire_filt)
   );

   pfpc_filter #(.WIDTH(8)) u_porta (
      .pclk(pclk), .presetn(presetn), .bypass(1'b0),
      .tick(pick_tick(porta_sel, 1'b1, tick_three, tick_one, tick_two)), // R5
      .sync_in(pin_sync[23:16]), .filt_out(porta_filt)
   );

   pfpc_filter #(.WIDTH(8)) u_portb (
      .pclk(pclk), .presetn(presetn), .bypass(1'b0),
      .tick(pick_tick(portb_sel, 1'b1, tick_three, tick_one, tick_two)), // R4
      .sync_in(pin_sync[15:8]), .filt_out(portb_filt)
   );

   pfpc_filter #(.WIDTH(8)) u_portc (
      .pclk(pclk), .presetn(presetn), .bypass(1'b0),
      .tick(pick_tick(portc_sel, 1'b1, tick_three, tick_one, tick_two)), // R3
      .sync_in(pin_sync[7:0]), .filt_out(portc_filt)
   );

   // ------------------------------------------------------------
   // pull-up control
   // ------------------------------------------------------------
   // outputs and hi-z pins never get the pull-up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portc_pullup_on <= 4'h0;
      end else begin
         portc_pullup_on <= pullup_en & ~portc_hi_output_en & portc_hi_input_en; // R7 R8
      end
   end
endmodule // pfpc_top
`default_nettype wire

/* pfpc_monitor.sv */
// assertion checker for the port filter and pull-up block
`timescale 1ns/10ps
`default_nettype none
module pfpc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] timer_channel_in,
   input wire logic two_wire_scl_in,
   input wire logic two_wire_sda_in,
   input wire logic [7:0] porta_in,
   input wire logic [3:0] portc_hi_output_en,
   input wire logic [3:0] portc_hi_input_en,
   input wire logic [1:0] timer_channel_filt,
   input wire logic [1:0] two_wire_filt,
   input wire logic [7:0] porta_filt,
   input wire logic [3:0] portc_pullup_on
);
   // ---------------------------------------------
   // shadow registers, updated as each write lands
   // ---------------------------------------------
   logic [31:0] flt;
   logic [31:0] pu;
   wire wr_ok = psel & penable & pready & pwrite;
   wire [3:0] pu_want = pu[21:18] & ~portc_hi_output_en & portc_hi_input_en;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt <= 32'h0;
         pu <= 32'h0;
      end else if (wr_ok && paddr == 12'h000) begin
         flt <= pwdata & 32'hff00_3c3f;
      end else if (wr_ok && paddr == 12'h004) begin
         pu <= pwdata & 32'h003c_0000;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   chk_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_unmapped_err: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
      else $error("pslverr wrong for address");
   chk_unmapped_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_filter_read: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == flt)
      else $error("filter select readback wrong");
   chk_pullup_read: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata == pu)
      else $error("pull-up readback wrong");
   chk_pullup_gate: assert property (portc_pullup_on == $past(pu_want))
      else $error("pull-up output wrong");
   chk_timer_bypass: assert property ((flt[13:12] == 2'b00 && $stable(timer_channel_in))[*4]
      |-> timer_channel_filt == timer_channel_in) else $error("timer bypass wrong");
   chk_two_wire_fast: assert property ((flt[11:10] == 2'b11
      && $stable({two_wire_scl_in, two_wire_sda_in}))[*5]
      |-> two_wire_filt == {two_wire_scl_in, two_wire_sda_in}) else $error("two-wire wrong");
   chk_porta_bus: assert property ((flt[1:0] == 2'b00 && $stable(porta_in))[*5]
      |-> porta_filt == porta_in) else $error("port a filter wrong");
   cov_pullup_on: cover property (portc_pullup_on != 4'h0);
   cov_slverr: cover property (pready && pslverr);
   cov_slow_set: cover property (wr_ok && pwdata[25:24] == 2'b11);
endmodule // pfpc_monitor
bind pfpc_top pfpc_monitor u_pfpc_monitor (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .timer_channel_in, .two_wire_scl_in, .two_wire_sda_in, .porta_in, .portc_hi_output_en,
   .portc_hi_input_en, .timer_channel_filt, .two_wire_filt, .porta_filt, .portc_pullup_on
);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the port filter and pull-up block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] timer_channel_in, timer_channel_filt, two_wire_filt;
   logic two_wire_scl_in, two_wire_sda_in;
   logic [7:0] porta_in, portb_in, portc_in, porta_filt, portb_filt, portc_filt;
   logic [3:0] portc_hi_output_en, portc_hi_input_en, portc_pullup_on;
   int n_fail = 0;
   int n_tests = 0;
   // filter setting, pulse width and filtered bits expected to rise, per row
   // widths stay at or below one tick period (blocked) or at two periods and more (passed)
   logic [31:0] cfg [10] = '{32'h0c00, 32'h0c00, 32'h0300_1415, 32'h1415, 32'h282a, 32'h303f,
      32'h0100_0015, 32'h0200_0015, 32'h2000_303f, 32'h0400_282a};
   int wid [10] = '{1, 2, 4, 4, 8, 8, 4, 16, 128, 64};
   logic [27:0] seen_exp [10] = '{28'hc00_0000, 28'hfff_ffff, 28'h0, 28'hfff_ffff, 28'h0,
      28'h300_0000, 28'hf00_0000, 28'hfff_ffff, 28'hfff_ffff, 28'h0};
   pfpc_top u_pfpc_top (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .timer_channel_in, .two_wire_scl_in, .two_wire_sda_in, .porta_in, .portb_in, .portc_in,
      .portc_hi_output_en, .portc_hi_input_en, .timer_channel_filt, .two_wire_filt,
      .porta_filt, .portb_filt, .portc_filt, .portc_pullup_on
   );
   // bus clock, 10 ns period
   always #5 pclk = ~pclk;
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic eerr);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         end_sim;
      end
      if (!wr) begin
         chk("prdata", exp, prdata);
      end
      chk("pslverr", {31'h0, eerr}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pulse every pin for w cycles, note which filtered groups ever rise
   // the long tail lets the slowest tick clear the filters before the next row
   task automatic glitch(input int w, input logic [27:0] exp);
      logic [27:0] seen;
      seen = '0;
      for (int i = 0; i < w + 200; i++) begin
         @(posedge pclk);
         {timer_channel_in, two_wire_scl_in, two_wire_sda_in, porta_in, portb_in, portc_in}
            <= (i < w) ? 28'hfff_ffff : 28'h0;
         @(negedge pclk);
         seen |= {timer_channel_filt, two_wire_filt, porta_filt, portb_filt, portc_filt};
      end
      chk("filtered", {4'h0, exp}, {4'h0, seen});
   endtask
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {timer_channel_in, two_wire_scl_in, two_wire_sda_in, porta_in, portb_in, portc_in} = '0;
      portc_hi_output_en = 4'h0;
      portc_hi_input_en = 4'hf;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h000, 0, 32'h0, 0);
      apb(0, 12'h004, 0, 32'h0, 0);
      apb(0, 12'h008, 0, 32'h0, 1);
      apb(1, 12'h000, 32'hffff_ffff, 0, 0);
      apb(1, 12'h004, 32'hffff_ffff, 0, 0);
      apb(1, 12'h00c, 32'h0, 0, 1);
      apb(0, 12'h000, 0, 32'hff00_3c3f, 0);
      apb(0, 12'h004, 0, 32'h003c_0000, 0);
      portc_hi_output_en <= 4'b0011;
      portc_hi_input_en <= 4'b1110;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("pullup", 32'hc, {28'h0, portc_pullup_on});
      apb(1, 12'h004, 32'h0014_0000, 0, 0);
      portc_hi_output_en <= 4'b0000;
      portc_hi_input_en <= 4'b1111;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("pullup", 32'h5, {28'h0, portc_pullup_on});
      for (int k = 0; k < 10; k++) begin
         apb(1, 12'h000, cfg[k], 0, 0);
         glitch(wid[k], seen_exp[k]);
      end
      end_sim;
   end
endmodule // testbench
`default_nettype wire
